/* File: design/fieldbus_status_pkg.sv */
`default_nettype none

package fieldbus_status_pkg;

  // main control word bit positions
  localparam int unsigned CTRL_ON_BIT = 0;
  localparam int unsigned CTRL_COAST_N_BIT = 1;
  localparam int unsigned CTRL_QUICK_N_BIT = 2;
  localparam int unsigned CTRL_FAULT_ACK_BIT = 7;
  localparam int unsigned CTRL_WATCHDOG_BIT = 11;

  // status word bit positions
  localparam int unsigned ST_READY_SW_ON = 0;
  localparam int unsigned ST_READY_OPER = 1;
  localparam int unsigned ST_RUNNING = 2;
  localparam int unsigned ST_FAULT = 3;
  localparam int unsigned ST_NO_COAST = 4;
  localparam int unsigned ST_NO_QUICK = 5;
  localparam int unsigned ST_INHIBIT = 6;
  localparam int unsigned ST_WARNING = 7;
  localparam int unsigned ST_AT_SPEED = 8;
  localparam int unsigned ST_BUS_CTRL = 9;
  localparam int unsigned ST_ABOVE_LIMIT = 10;
  localparam int unsigned ST_SEL_LO = 11;
  localparam int unsigned ST_WATCHDOG_ECHO = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // combination-3 control word bit positions
  localparam int unsigned ALT_START_BIT = 0;
  localparam int unsigned ALT_CCW_BIT = 1;
  localparam int unsigned ALT_RESET_BIT = 2;
  localparam int unsigned ALT_DIN_LO = 3;
  localparam int unsigned ALT_DIN_HI = 7;

  // watchdog timebase: delay setting counts in milliseconds
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned WD_TICK_US = 1000;
  localparam int unsigned WD_TICK_CYCLES = (CLK_HZ / 1_000_000) * WD_TICK_US;

  typedef enum logic [2:0] {
    SW_INHIBIT = 3'b001,
    SW_ARMED   = 3'b010,
    SW_ENABLED = 3'b100
  } switch_state_t;

  typedef struct packed {
    logic init_done;
    logic run;
    logic modulating;
    logic flux_ready;
    logic brake_open;
    logic brake_fb_used;
    logic fault;
    logic warning;
    logic bus_has_control;
  } drive_state_t;

endpackage

`default_nettype wire

/* File: design/fieldbus_status_word_logic.sv */
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - with monitoring on and a delay below FFFF, a watchdog bit that stops toggling raises the fault state
// - a zero delay setting disables watchdog monitoring entirely
// - b0 low on fault or inhibit, high when initialised and pulses inhibited
// - b1 is b0 AND the ON command bit
// - b2 high only when running, modulating, flux ready, brake open if used
// - b3 mirrors the fault state
// - b4 low during coast stop, b5 low during quick stop
// - b6 clears only after stops released, then OFF, then ON
// - b7 follows warnings, clears itself without acknowledgement
// - b8 high when actual speed is within tolerance of reference
// - b9 high when the fieldbus master has control
// - b10 high when actual speed exceeds the above-speed limit
// - b11..b14 each copy one internal bit picked by its own select
// - b15 echoes control word bit 11 back to the master
// - combination-3 word: start, direction, fault reset, five bus digital inputs, rest ignored
// - combination-3 fault reset only on a rising edge of bit2
// - control bit1 low means coast stop and switch-on inhibit
// - control bit2 low requests the configured quick stop
// - control bit11 carries the master's watchdog square wave
module fieldbus_status_word_logic #(
  parameter int unsigned TICK_CYCLES = fieldbus_status_pkg::WD_TICK_CYCLES
) (
  input wire logic clk_i, // 25 MHz system clock
  input wire logic reset_i, // synchronous, active high
  input wire logic cycle_strobe_i, // one pulse per process-data cycle
  input wire logic [15:0] ctrl_word_i, // main control word from master
  input wire logic [15:0] alt_ctrl_word_i, // combination-3 control word
  input wire fieldbus_status_pkg::drive_state_t drive_i, // drive state flags
  input wire logic [15:0] speed_actual_i, // actual speed magnitude
  input wire logic [15:0] speed_ref_i, // speed reference magnitude
  input wire logic [15:0] speed_tolerance_i, // at-speed window
  input wire logic [15:0] above_speed_limit_setting_i, // above-limit threshold
  input wire logic [63:0] selectable_status_bit_i, // internal bits to pick from
  input wire logic [5:0] status_bit11_select_i, // index for b11
  input wire logic [5:0] status_bit12_select_i, // index for b12
  input wire logic [5:0] status_bit13_select_i, // index for b13
  input wire logic [5:0] status_bit14_select_i, // index for b14
  input wire logic [15:0] watchdog_delay_setting_i, // ms, zero disables
  output logic [15:0] status_word_o, // fieldbus status word
  output logic coast_stop_o, // coast stop command level
  output logic quick_stop_o, // quick stop command level
  output logic watchdog_fault_o, // bus communication fault, sticky
  output logic alt_start_o, // combination-3 start
  output logic alt_ccw_o, // combination-3 counter-clockwise
  output logic [4:0] bus_digital_input_o, // bus digital inputs one to five
  output logic fault_reset_o // one-cycle fault reset pulse
);

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] ctrl_q;
  logic [15:0] alt_q;
  logic wd_prev_q;
  logic [15:0] wd_cnt_q;
  logic wd_fault_q;
  logic [15:0] tick_cnt_q;
  logic tick;
  logic wd_expired;
  logic wd_toggled;
  logic fault_now;
  logic ack_rise;
  logic alt_rise;
  fieldbus_status_pkg::switch_state_t sw_q;
  fieldbus_status_pkg::switch_state_t sw_d;

  function automatic logic within_tol(input logic [15:0] a, input logic [15:0] b,
                                      input logic [15:0] tol);
    logic [15:0] diff;
    diff = (a > b) ? 16'(a - b) : 16'(b - a);
    return diff <= tol;
  endfunction

  // millisecond enable for the watchdog counter
  always_ff @(posedge clk_i)
  begin
    if (reset_i || tick)
      tick_cnt_q <= 16'h0000;
    else
      tick_cnt_q <= 16'(tick_cnt_q + 16'h0001);
  end
  assign tick = (tick_cnt_q == TICK_LAST);

  // control words are only looked at on the cycle strobe
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= 16'h0000;
      alt_q <= 16'h0000;
      wd_prev_q <= 1'b0;
    end
    else if (cycle_strobe_i)
    begin
      ctrl_q <= ctrl_word_i;
      alt_q <= alt_ctrl_word_i;
      wd_prev_q <= ctrl_word_i[fieldbus_status_pkg::CTRL_WATCHDOG_BIT];
    end
  end

  assign wd_toggled = cycle_strobe_i &&
    (ctrl_word_i[fieldbus_status_pkg::CTRL_WATCHDOG_BIT] != wd_prev_q);
  assign wd_expired = (watchdog_delay_setting_i != 16'h0000) &&
    (wd_cnt_q > watchdog_delay_setting_i);

  // saturates at FFFF so a dead master keeps the count past any delay below FFFF
  always_ff @(posedge clk_i)
  begin
    if (reset_i || wd_toggled)
      wd_cnt_q <= 16'h0000;
    else if (tick && wd_cnt_q != 16'hFFFF)
      wd_cnt_q <= 16'(wd_cnt_q + 16'h0001);
  end

  assign ack_rise = cycle_strobe_i && ctrl_word_i[fieldbus_status_pkg::CTRL_FAULT_ACK_BIT] &&
    !ctrl_q[fieldbus_status_pkg::CTRL_FAULT_ACK_BIT];
  assign alt_rise = cycle_strobe_i && alt_ctrl_word_i[fieldbus_status_pkg::ALT_RESET_BIT] &&
    !alt_q[fieldbus_status_pkg::ALT_RESET_BIT];

  // a timeout in the same cycle as an acknowledge keeps the fault
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      wd_fault_q <= 1'b0;
    else if (wd_expired)
      wd_fault_q <= 1'b1;
    else if (ack_rise || alt_rise)
      wd_fault_q <= 1'b0;
  end

  assign fault_now = drive_i.fault || wd_fault_q;

  // switch-on inhibit sequence, evaluated per bus cycle
  always_comb
  begin
    sw_d = sw_q;
    if (!ctrl_word_i[fieldbus_status_pkg::CTRL_COAST_N_BIT] ||
        !ctrl_word_i[fieldbus_status_pkg::CTRL_QUICK_N_BIT] || fault_now)
      sw_d = fieldbus_status_pkg::SW_INHIBIT;
    else
    begin
      unique case (sw_q)
        fieldbus_status_pkg::SW_INHIBIT:
          if (!ctrl_word_i[fieldbus_status_pkg::CTRL_ON_BIT])
            sw_d = fieldbus_status_pkg::SW_ARMED;
        fieldbus_status_pkg::SW_ARMED:
          if (ctrl_word_i[fieldbus_status_pkg::CTRL_ON_BIT])
            sw_d = fieldbus_status_pkg::SW_ENABLED;
        fieldbus_status_pkg::SW_ENABLED:
          sw_d = fieldbus_status_pkg::SW_ENABLED;
        default:
          sw_d = fieldbus_status_pkg::SW_INHIBIT;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sw_q <= fieldbus_status_pkg::SW_INHIBIT;
    else if (cycle_strobe_i)
      sw_q <= sw_d;
  end

  // next status word built from the same-cycle inputs for coherence
  always_comb
  begin
    logic inhibit;
    logic ready;
    inhibit = (sw_d != fieldbus_status_pkg::SW_ENABLED);
    ready = drive_i.init_done && !fault_now && !inhibit;
    status_d = 16'h0000;
    status_d[fieldbus_status_pkg::ST_READY_SW_ON] = ready;
    status_d[fieldbus_status_pkg::ST_READY_OPER] =
      ready && ctrl_word_i[fieldbus_status_pkg::CTRL_ON_BIT];
    status_d[fieldbus_status_pkg::ST_RUNNING] = drive_i.run && drive_i.modulating &&
      drive_i.flux_ready && (drive_i.brake_open || !drive_i.brake_fb_used);
    status_d[fieldbus_status_pkg::ST_FAULT] = fault_now;
    status_d[fieldbus_status_pkg::ST_NO_COAST] =
      ctrl_word_i[fieldbus_status_pkg::CTRL_COAST_N_BIT];
    status_d[fieldbus_status_pkg::ST_NO_QUICK] =
      ctrl_word_i[fieldbus_status_pkg::CTRL_QUICK_N_BIT];
    status_d[fieldbus_status_pkg::ST_INHIBIT] = inhibit;
    status_d[fieldbus_status_pkg::ST_WARNING] = drive_i.warning;
    status_d[fieldbus_status_pkg::ST_AT_SPEED] =
      within_tol(speed_actual_i, speed_ref_i, speed_tolerance_i);
    status_d[fieldbus_status_pkg::ST_BUS_CTRL] = drive_i.bus_has_control;
    status_d[fieldbus_status_pkg::ST_ABOVE_LIMIT] =
      speed_actual_i > above_speed_limit_setting_i;
    status_d[fieldbus_status_pkg::ST_SEL_LO] =
      selectable_status_bit_i[status_bit11_select_i];
    status_d[fieldbus_status_pkg::ST_SEL_LO + 1] =
      selectable_status_bit_i[status_bit12_select_i];
    status_d[fieldbus_status_pkg::ST_SEL_LO + 2] =
      selectable_status_bit_i[status_bit13_select_i];
    status_d[fieldbus_status_pkg::ST_SEL_LO + 3] =
      selectable_status_bit_i[status_bit14_select_i];
    status_d[fieldbus_status_pkg::ST_WATCHDOG_ECHO] =
      ctrl_word_i[fieldbus_status_pkg::CTRL_WATCHDOG_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      status_q <= fieldbus_status_pkg::STATUS_RESET;
    else if (cycle_strobe_i)
      status_q <= status_d;
  end

  // fault reset pulse; bits 8..15 of the alternate word are never read
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      fault_reset_o <= 1'b0;
    else
      fault_reset_o <= alt_rise || ack_rise;
  end

  assign status_word_o = status_q;
  assign coast_stop_o = !ctrl_q[fieldbus_status_pkg::CTRL_COAST_N_BIT];
  assign quick_stop_o = !ctrl_q[fieldbus_status_pkg::CTRL_QUICK_N_BIT];
  assign watchdog_fault_o = wd_fault_q;
  assign alt_start_o = alt_q[fieldbus_status_pkg::ALT_START_BIT];
  assign alt_ccw_o = alt_q[fieldbus_status_pkg::ALT_CCW_BIT];
  assign bus_digital_input_o =
    alt_q[fieldbus_status_pkg::ALT_DIN_HI:fieldbus_status_pkg::ALT_DIN_LO];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_wd_off_quiet: assert property (
    (watchdog_delay_setting_i == 16'h0000 && !wd_fault_q) |=> !wd_fault_q)
    else $error("watchdog fault raised with monitoring off");

  chk_wd_timeout_raise: assert property (
    (watchdog_delay_setting_i != 16'h0000 && wd_cnt_q > watchdog_delay_setting_i)
    |=> wd_fault_q)
    else $error("watchdog timeout did not raise fault");

  chk_wd_count_restart: assert property (
    wd_toggled |=> wd_cnt_q == 16'h0000)
    else $error("watchdog counter not restarted on toggle");

  chk_echo_bit: assert property (
    cycle_strobe_i |=> status_q[15] == $past(ctrl_word_i[11]))
    else $error("watchdog echo wrong");

  chk_ready_oper_and: assert property (
    cycle_strobe_i |=> status_q[1] == (status_q[0] && ctrl_q[0]))
    else $error("ready to operate not ready AND on");

  chk_fault_bit: assert property (
    cycle_strobe_i |=> status_q[3] == $past(fault_now))
    else $error("fault bit mismatch");

  chk_stop_bits: assert property (
    cycle_strobe_i |=> status_q[5:4] == $past(ctrl_word_i[2:1]))
    else $error("stop status bits wrong");

  chk_coast_inhibit: assert property (
    (cycle_strobe_i && !ctrl_word_i[1]) |=> sw_q == fieldbus_status_pkg::SW_INHIBIT
    && status_q[6])
    else $error("coast stop did not inhibit");

  chk_alt_reset_edge: assert property (
    fault_reset_o |-> $past(cycle_strobe_i) && ($past(alt_ctrl_word_i[2]) && !$past(alt_q[2])
    || $past(ack_rise)))
    else $error("fault reset without rising edge");

  chk_status_hold: assert property (
    !cycle_strobe_i |=> $stable(status_q))
    else $error("status changed between bus cycles");

  chk_ready_sw_on: assert property (
    status_q[0] |-> !status_q[3] && !status_q[6])
    else $error("ready to switch on while faulted or inhibited");

  chk_fault_inhibit: assert property (
    (cycle_strobe_i && fault_now) |=> status_q[6] && !status_q[0])
    else $error("fault did not force switch-on inhibit");

  chk_running_gate: assert property (
    (cycle_strobe_i && !(drive_i.run && drive_i.modulating && drive_i.flux_ready))
    |=> !status_q[2])
    else $error("running bit set while not modulating");

  chk_running_brake: assert property (
    (cycle_strobe_i && drive_i.brake_fb_used && !drive_i.brake_open) |=> !status_q[2])
    else $error("running bit set with brake closed");

  chk_warning_bit: assert property (
    cycle_strobe_i |=> status_q[7] == $past(drive_i.warning))
    else $error("warning bit does not follow warning");

  chk_at_speed_equal: assert property (
    (cycle_strobe_i && speed_actual_i == speed_ref_i) |=> status_q[8])
    else $error("speed at reference not reported");

  chk_bus_ctrl: assert property (
    cycle_strobe_i |=> status_q[9] == $past(drive_i.bus_has_control))
    else $error("bus control bit mismatch");

  chk_above_limit_set: assert property (
    (cycle_strobe_i && speed_actual_i > above_speed_limit_setting_i) |=> status_q[10])
    else $error("above limit bit not set");

  chk_above_limit_clear: assert property (
    (cycle_strobe_i && speed_actual_i <= above_speed_limit_setting_i) |=> !status_q[10])
    else $error("above limit bit set below limit");

  chk_inhibit_no_skip: assert property (
    (cycle_strobe_i && sw_q == fieldbus_status_pkg::SW_INHIBIT)
    |=> sw_q != fieldbus_status_pkg::SW_ENABLED)
    else $error("switch-on inhibit left without OFF first");

  chk_quick_inhibit: assert property (
    (cycle_strobe_i && !ctrl_word_i[2]) |=> quick_stop_o
    && sw_q == fieldbus_status_pkg::SW_INHIBIT)
    else $error("quick stop not applied");

  chk_alt_outputs: assert property (
    cycle_strobe_i |=> bus_digital_input_o == $past(alt_ctrl_word_i[7:3])
    && alt_start_o == $past(alt_ctrl_word_i[0]) && alt_ccw_o == $past(alt_ctrl_word_i[1]))
    else $error("combination-3 outputs wrong");

  chk_wd_sticky: assert property (
    (wd_fault_q && !ack_rise && !alt_rise) |=> wd_fault_q)
    else $error("watchdog fault dropped without reset");

  cov_wd_fault: cover property (!wd_fault_q ##1 wd_fault_q);
  cov_leave_inhibit: cover property (sw_q == fieldbus_status_pkg::SW_ARMED
    ##[1:1000] sw_q == fieldbus_status_pkg::SW_ENABLED);
  cov_alt_reset: cover property (wd_fault_q ##1 (fault_reset_o && !wd_fault_q));
  cov_enabled_off: cover property (sw_q == fieldbus_status_pkg::SW_ENABLED
    && cycle_strobe_i && !ctrl_word_i[0]);

endmodule

`default_nettype wire

/* File: verification/plc_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
module plc_master_model #(
  parameter int unsigned PERIOD = 5,
  parameter int unsigned HALF = 2
) (
  input wire logic clk_i, // system clock
  input wire logic [15:0] cmd_i, // command bits, bit11 ignored
  input wire logic wd_run_i, // keep the watchdog wave going
  output logic cycle_strobe_o, // process-data cycle pulse
  output logic [15:0] ctrl_word_o // control word to the drive
);
  int unsigned cyc = 0;
  int unsigned half_cnt = 0;
  logic wd_bit = 1'b0;
  always @(negedge clk_i)
  begin
    cyc = (cyc + 1) % PERIOD;
    cycle_strobe_o <= (cyc == 0);
    if (cyc == 0 && wd_run_i)
    begin
      half_cnt = (half_cnt + 1) % HALF;
      if (half_cnt == 0)
        wd_bit = !wd_bit; // square wave scaled down in time
    end
  end
  // on command and stop bits come straight from the bench
  assign ctrl_word_o = {cmd_i[15:12], wd_bit, cmd_i[10:0]};
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHECK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
      num_errors++; \
      $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic strobe;
  logic [15:0] cmd = 16'h0006;
  logic wd_run = 1'b1;
  logic [15:0] ctrl_word;
  logic [15:0] alt_word = 16'h0000;
  fieldbus_status_pkg::drive_state_t drive = '0;
  logic [15:0] act = 16'h0000;
  logic [15:0] spd_ref = 16'h0000;
  logic [15:0] tol = 16'h0000;
  logic [15:0] lim = 16'h0000;
  logic [63:0] sel_bits = '0;
  logic [23:0] sel = '0;
  logic [15:0] wd_delay = 16'h0004;
  logic [15:0] status;
  logic coast, quick, wdf, start, ccw, fres;
  logic [4:0] din;
  int num_errors = 0;
  int cmp_count = 0;
  int pulses = 0;
  fieldbus_status_pkg::switch_state_t st = fieldbus_status_pkg::SW_INHIBIT;

  plc_master_model u_plc (.clk_i(clk_i), .cmd_i(cmd), .wd_run_i(wd_run),
    .cycle_strobe_o(strobe), .ctrl_word_o(ctrl_word));
  fieldbus_status_word_logic #(.TICK_CYCLES(4)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
    .cycle_strobe_i(strobe), .ctrl_word_i(ctrl_word), .alt_ctrl_word_i(alt_word),
    .drive_i(drive), .speed_actual_i(act), .speed_ref_i(spd_ref), .speed_tolerance_i(tol),
    .above_speed_limit_setting_i(lim), .selectable_status_bit_i(sel_bits),
    .status_bit11_select_i(sel[5:0]), .status_bit12_select_i(sel[11:6]),
    .status_bit13_select_i(sel[17:12]), .status_bit14_select_i(sel[23:18]),
    .watchdog_delay_setting_i(wd_delay), .status_word_o(status), .coast_stop_o(coast),
    .quick_stop_o(quick), .watchdog_fault_o(wdf), .alt_start_o(start), .alt_ccw_o(ccw),
    .bus_digital_input_o(din), .fault_reset_o(fres));

  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (fres === 1'b1) pulses++;

  function automatic fieldbus_status_pkg::switch_state_t next_state(input logic [15:0] cw,
    input logic flt);
    if (!cw[1] || !cw[2] || flt)
      return fieldbus_status_pkg::SW_INHIBIT;
    if (st == fieldbus_status_pkg::SW_INHIBIT)
      return cw[0] ? fieldbus_status_pkg::SW_INHIBIT : fieldbus_status_pkg::SW_ARMED;
    if (st == fieldbus_status_pkg::SW_ENABLED)
      return fieldbus_status_pkg::SW_ENABLED;
    return cw[0] ? fieldbus_status_pkg::SW_ENABLED : fieldbus_status_pkg::SW_ARMED;
  endfunction

  function automatic logic [15:0] exp_status(input logic [15:0] cw, input logic flt);
    logic [15:0] s;
    logic [15:0] diff;
    diff = (act >= spd_ref) ? act - spd_ref : spd_ref - act;
    s[0] = drive.init_done && !flt && st == fieldbus_status_pkg::SW_ENABLED;
    s[1] = s[0] && cw[0];
    s[2] = drive.run && drive.modulating && drive.flux_ready
      && (drive.brake_open || !drive.brake_fb_used);
    s[3] = flt;
    s[4] = cw[1];
    s[5] = cw[2];
    s[6] = st != fieldbus_status_pkg::SW_ENABLED;
    s[7] = drive.warning;
    s[8] = diff <= tol;
    s[9] = drive.bus_has_control;
    s[10] = act > lim;
    s[11] = sel_bits[sel[5:0]];
    s[12] = sel_bits[sel[11:6]];
    s[13] = sel_bits[sel[17:12]];
    s[14] = sel_bits[sel[23:18]];
    s[15] = cw[11];
    return s;
  endfunction

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic shuffle(input int i);
    cmd = 16'($urandom);
    cmd[2:1] = (i % 7 == 3) ? 2'($urandom) : 2'b11;
    cmd[0] = i[1];
    drive = fieldbus_status_pkg::drive_state_t'(9'($urandom));
    drive.fault = ($urandom % 8) == 0;
    act = 16'($urandom);
    spd_ref = act + 16'($urandom % 128) - 16'h0040;
    tol = 16'($urandom % 64);
    lim = (i % 5 == 0) ? act : 16'($urandom);
    sel_bits = {$urandom, $urandom};
    sel = 24'($urandom);
    alt_word = 16'($urandom);
  endtask

  task automatic sample(input logic wfault);
    logic [15:0] cw;
    logic flt;
    logic [15:0] want;
    @(posedge clk_i iff strobe);
    cw = ctrl_word;
    flt = drive.fault | wfault;
    st = next_state(cw, flt);
    @(negedge clk_i);
    @(negedge clk_i);
    want = exp_status(cw, flt);
    `CHECK(status[7:0], want[7:0])
    `CHECK(status[15:8], want[15:8])
    `CHECK({coast, quick}, {!cw[1], !cw[2]})
    `CHECK({din, ccw, start}, {alt_word[7:3], alt_word[1:0]})
    `CHECK(wdf, wfault)
  endtask

  task automatic wait_strobes(input int n);
    repeat (n) @(posedge clk_i iff strobe);
    repeat (2) @(negedge clk_i);
  endtask

  initial
  begin
    #400000;
    num_errors++;
    end_of_test;
  end

  initial
  begin
    void'($urandom(32'h0D95));
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    `CHECK(status, fieldbus_status_pkg::STATUS_RESET)
    for (int i = 0; i < 60; i++)
    begin
      shuffle(i);
      if (i >= 40)
      begin
        wd_run = 1'b0;
        wd_delay = 16'h0000;
      end
      sample(1'b0);
    end
    cmd[7] = 1'b0;
    alt_word[2] = 1'b0;
    wd_delay = 16'h0002;
    for (int n = 0; n < 60 && wdf !== 1'b1; n++) @(negedge clk_i);
    `CHECK(wdf, 1'b1)
    sample(1'b1);
    wd_run = 1'b1;
    wd_delay = 16'h0004;
    wait_strobes(5);
    pulses = 0;
    cmd[7] = 1'b1;
    wait_strobes(3);
    `CHECK(wdf, 1'b0)
    `CHECK(pulses, 1)
    cmd[7] = 1'b0;
    sample(1'b0);
    pulses = 0;
    alt_word[2] = 1'b1;
    wait_strobes(4);
    `CHECK(pulses, 1)
    sample(1'b0);
    end_of_test;
  end
endmodule
`default_nettype wire
